/* File: rtl/part_state_ctrl.sv */
// Partition state controller: per-partition state, sequencing and status.
// Assumes an APB master on pclk, and port-mode logic answering mode_req with mode_ack.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module part_state_ctrl
    import part_state_pkg::*;
#(
    parameter int NPART      = 4,
    parameter int NPORT      = 8,
    parameter int DRAIN_CYC  = RESET_DRAIN_CYC
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic      [31:0]        prdata,
    output logic                    pslverr,
    // Partition reset pins, active low, asynchronous
    input  wire logic [NPART-1:0]   partition_reset_input_n,
    // Port mode change handshake
    output logic      [NPORT-1:0]   mode_req,
    input  wire logic [NPORT-1:0]   mode_ack,
    // Per-partition outputs
    output logic      [NPART-1:0]   part_reset,
    output logic      [NPART-1:0]   part_active,
    // Per-port outputs
    output logic      [NPORT-1:0]   port_force_disabled,
    output logic      [NPORT-1:0]   port_reset
);

    localparam int PW = $clog2(NPART) > 0 ? $clog2(NPART) : 1;
    localparam int CW = $clog2(DRAIN_CYC + 1) + 9;

    typedef struct packed {
        logic [NPART-1:0][1:0]    state;
        logic [NPART-1:0]         begun;
        logic [NPART-1:0]         done;
        logic [NPART-1:0][3:0]    seq;
        logic [NPART-1:0][CW-1:0] cnt;
        logic [7:0]               t_side;
        logic [7:0]               t_pmode;
        logic [7:0]               t_rdrain;
        logic [7:0]               t_usbr;
        logic [NPORT-1:0]         port_mode_en;
        logic [NPORT-1:0][PW-1:0] port_part;
        logic [NPORT-1:0]         mreq;
        logic [NPART-1:0]         rst_s1;
        logic [NPART-1:0]         rst_s2;
        logic [31:0]              rdata;
    } st_t;

    st_t s_r;
    st_t s_nxt;

    logic access;
    assign access  = psel & penable;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = s_r.rdata;
    assign mode_req = s_r.mreq;

    // Port attached to partition p and operational
    function automatic logic port_in(input st_t s, input int q, input int p);
        return s.port_mode_en[q] && (int'(s.port_part[q]) == p);
    endfunction : port_in

    always_comb begin
        logic [11:0] a;
        logic        pin_rst;
        logic        pend_ack;
        logic [CW-1:0] drain;
        a        = paddr;
        pin_rst  = 1'b0;
        pend_ack = 1'b0;
        drain    = '0;
        s_nxt    = s_r;
        s_nxt.rst_s1 = ~partition_reset_input_n;
        s_nxt.rst_s2 = s_r.rst_s1;

        // Register writes
        if (access && pwrite) begin
            for (int p = 0; p < NPART; p++) begin
                if (a == OFF_CTL_BASE + 12'(p * PART_STRIDE)) begin
                    s_nxt.state[p] = pwdata[1:0];
                    s_nxt.begun[p] = 1'b1;
                    s_nxt.done[p]  = 1'b0;
                    s_nxt.seq[p]   = SQ_IDLE;
                    if (pwdata[1:0] == PST_FRESET && s_r.state[p] != PST_FRESET) begin
                        drain = CW'(s_r.t_rdrain) * CW'(DRAIN_CYC);
                        s_nxt.cnt[p] = drain;
                        s_nxt.seq[p] = SQ_DRAIN;
                    end else begin
                        s_nxt.cnt[p] = CW'(s_r.t_side);
                        s_nxt.seq[p] = SQ_PMODE;
                    end
                end
                if (a == OFF_STS_BASE + 12'(p * PART_STRIDE)) begin
                    if (pwdata[STS_BEGUN_BIT]) s_nxt.begun[p] = 1'b0;
                    if (pwdata[STS_DONE_BIT])  s_nxt.done[p]  = 1'b0;
                end
            end
            if (a == OFF_TIMER) begin
                s_nxt.t_side   = pwdata[TMR_SIDE_LSB +: 8];
                s_nxt.t_pmode  = pwdata[TMR_PMODE_LSB +: 8];
                s_nxt.t_rdrain = pwdata[TMR_RDRAIN_LSB +: 8];
                s_nxt.t_usbr   = pwdata[TMR_USBR_LSB +: 8];
            end
            for (int q = 0; q < NPORT; q++) begin
                if (a == OFF_PORT_BASE + 12'(q * PART_STRIDE)) begin
                    s_nxt.port_mode_en[q] = pwdata[0];
                    s_nxt.port_part[q]    = pwdata[4 +: PW];
                end
            end
        end

        // Sequencers
        for (int p = 0; p < NPART; p++) begin
            pin_rst  = s_r.rst_s2[p];
            pend_ack = 1'b0;
            for (int q = 0; q < NPORT; q++) begin
                if (port_in(s_r, q, p) && s_r.mreq[q] && !mode_ack[q]) pend_ack = 1'b1;
            end
            case (s_r.seq[p])
                SQ_IDLE: begin
                end
                SQ_DRAIN: begin
                    if (s_r.cnt[p] == '0) begin
                        s_nxt.cnt[p] = CW'(s_r.t_side);
                        s_nxt.seq[p] = SQ_PMODE;
                    end else begin
                        s_nxt.cnt[p] = s_r.cnt[p] - 1'b1;
                    end
                end
                SQ_PMODE: begin
                    for (int q = 0; q < NPORT; q++) begin
                        if (port_in(s_r, q, p)) s_nxt.mreq[q] = 1'b1;
                    end
                    if (s_r.cnt[p] != '0) begin
                        s_nxt.cnt[p] = s_r.cnt[p] - 1'b1;
                    end else begin
                        s_nxt.cnt[p] = CW'(s_r.t_pmode);
                        s_nxt.seq[p] = SQ_HOLD;
                    end
                end
                SQ_HOLD: begin
                    if (s_r.cnt[p] != '0) begin
                        s_nxt.cnt[p] = s_r.cnt[p] - 1'b1;
                    end else if (!pend_ack &&
                                 !(pin_rst && s_r.state[p] == PST_ACTIVE)) begin
                        s_nxt.done[p] = 1'b1;
                        s_nxt.seq[p]  = SQ_IDLE;
                    end
                end
                default: s_nxt.seq[p] = SQ_IDLE;
            endcase
        end
        for (int q = 0; q < NPORT; q++) begin
            if (s_r.mreq[q] && mode_ack[q]) s_nxt.mreq[q] = 1'b0;
        end

        // Reset entry, at drain end, returns partition-owned ports to mode disabled
        for (int p = 0; p < NPART; p++) begin
            if (s_r.state[p] == PST_FRESET && s_r.seq[p] == SQ_DRAIN && s_r.cnt[p] == '0) begin
                for (int q = 0; q < NPORT; q++) begin
                    if (port_in(s_r, q, p)) begin
                        s_nxt.port_mode_en[q] = 1'b0;
                        s_nxt.port_part[q]    = PW'(p);
                    end
                end
            end
        end

        // Read data
        s_nxt.rdata = '0;
        if (psel && !penable && !pwrite) begin
            for (int p = 0; p < NPART; p++) begin
                if (a == OFF_CTL_BASE + 12'(p * PART_STRIDE)) s_nxt.rdata[1:0] = s_r.state[p];
                if (a == OFF_STS_BASE + 12'(p * PART_STRIDE)) begin
                    s_nxt.rdata[STS_BEGUN_BIT] = s_r.begun[p];
                    s_nxt.rdata[STS_DONE_BIT]  = s_r.done[p];
                    s_nxt.rdata[STS_BUSY_BIT]  = s_r.seq[p] != SQ_IDLE;
                    s_nxt.rdata[STS_RESET_BIT] = s_r.rst_s2[p];
                end
            end
            if (a == OFF_TIMER)
                s_nxt.rdata = {s_r.t_usbr, s_r.t_rdrain, s_r.t_pmode, s_r.t_side};
            for (int q = 0; q < NPORT; q++) begin
                if (a == OFF_PORT_BASE + 12'(q * PART_STRIDE))
                    s_nxt.rdata[7:0] = 8'({s_r.port_part[q], 3'h0, s_r.port_mode_en[q]});
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r          <= '0;
            s_r.seq      <= {NPART{SQ_IDLE}};
            s_r.t_side   <= SIDE_RESET;
            s_r.t_pmode  <= PMODE_RESET;
            s_r.t_rdrain <= RDRAIN_RESET;
            s_r.t_usbr   <= USBR_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Per-partition and per-port controls
    genvar gp;
    generate
        for (gp = 0; gp < NPART; gp++) begin : g_part
            assign part_reset[gp]  = s_r.state[gp] == PST_FRESET;
            assign part_active[gp] = s_r.state[gp] == PST_ACTIVE;
        end
        for (gp = 0; gp < NPORT; gp++) begin : g_port
            logic [1:0] ps;
            assign ps = s_r.state[s_r.port_part[gp]];
            assign port_force_disabled[gp] = s_r.port_mode_en[gp] && ps == PST_DISABLED;
            assign port_reset[gp]          = s_r.port_mode_en[gp] && ps == PST_FRESET;
        end
    endgenerate

endmodule : part_state_ctrl

/* File: rtl/part_state_pkg.sv */
// Package for the partition state controller: offsets, fields, codes, timing.
// Assumes a 50 MHz APB clock; registers are 32-bit aligned words.
package part_state_pkg;

    // State field codes
    typedef enum logic [1:0] {
        PST_DISABLED = 2'h0,
        PST_FRESET   = 2'h1,
        PST_ACTIVE   = 2'h2
    } part_state_t;

    // Register byte offsets, stride per partition
    localparam logic [11:0] OFF_CTL_BASE   = 12'h000;
    localparam logic [11:0] OFF_STS_BASE   = 12'h100;
    localparam logic [11:0] OFF_TIMER      = 12'h200;
    localparam logic [11:0] OFF_PORT_BASE  = 12'h300;
    localparam int          PART_STRIDE    = 4;

    // Status bit positions
    localparam int STS_BEGUN_BIT = 0;
    localparam int STS_DONE_BIT  = 1;
    localparam int STS_BUSY_BIT  = 2;
    localparam int STS_RESET_BIT = 3;

    // Timer register field positions
    localparam int TMR_SIDE_LSB   = 0;
    localparam int TMR_PMODE_LSB  = 8;
    localparam int TMR_RDRAIN_LSB = 16;
    localparam int TMR_USBR_LSB   = 24;

    // Reset values
    localparam logic [1:0] CTL_RESET   = 2'h0;
    localparam logic [7:0] SIDE_RESET  = 8'h04;
    localparam logic [7:0] PMODE_RESET = 8'h04;
    localparam logic [7:0] USBR_RESET  = 8'h04;

    // Drain time on entry to fundamental reset
    localparam int CLK_MHZ         = 50;
    localparam int RESET_DRAIN_US  = 250;
    localparam int RESET_DRAIN_CYC = RESET_DRAIN_US * CLK_MHZ;
    localparam logic [7:0] RDRAIN_RESET = 8'h01;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        SQ_IDLE  = 4'b0001,
        SQ_DRAIN = 4'b0010,
        SQ_PMODE = 4'b0100,
        SQ_HOLD  = 4'b1000
    } seq_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_t;

endpackage : part_state_pkg

/* File: testbench/part_state_ctrl_props.sv */
// Checker for the partition state controller, bound to its ports.
// Assumes partition 0 reset pin stays high.
`timescale 1ns/10ps
module part_state_ctrl_props
    import part_state_pkg::*;
#(
    parameter int NPART = 4,
    parameter int NPORT = 8
) (
    // Clock, reset, APB
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    input wire logic [31:0]      prdata,
    input wire logic             pslverr,
    // Handshake and state
    input wire logic [NPORT-1:0] mode_req,
    input wire logic [NPORT-1:0] mode_ack,
    input wire logic [NPART-1:0] part_reset,
    input wire logic [NPART-1:0] part_active
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic w0;
    assign w0 = psel && penable && pwrite && paddr == OFF_CTL_BASE;
    no_wait_a: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    no_error_a: assert property (psel && penable |-> !pslverr)
        else $error("slave error raised");
    one_state_a: assert property ((part_reset & part_active) == '0)
        else $error("partition reset and active together");
    reset_entry_a: assert property (w0 && pwdata[1:0] == PST_FRESET |-> ##[1:2] part_reset[0])
        else $error("reset not entered");
    reset_hold_a: assert property (part_reset[0] && !w0 |=> part_reset[0])
        else $error("reset dropped without write");
    reset_leave_a: assert property (w0 && pwdata[1:0] == PST_DISABLED |-> ##[1:2] !part_reset[0] && !part_active[0])
        else $error("disable not taken");
    mode_hold_a: assert property (mode_req[1] && !mode_ack[1] |=> mode_req[1])
        else $error("mode request withdrawn early");
    unmapped_rd_a: assert property (psel && penable && !pwrite && paddr == 12'hffc |-> prdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : part_state_ctrl_props

bind part_state_ctrl part_state_ctrl_props #(.NPART(NPART), .NPORT(NPORT)) props_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .mode_req, .mode_ack, .part_reset, .part_active);

/* File: testbench/port_mode_model.sv */
// Port-mode logic stand-in: acknowledges a mode request after a delay.
// Assumes a level handshake on the controller clock.
`timescale 1ns/10ps
module port_mode_model #(
    parameter int NPORT = 8,
    parameter int DELAY = 6
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Handshake
    input  wire logic [NPORT-1:0] mode_req,
    output logic      [NPORT-1:0] mode_ack
);
    int cnt [NPORT];
    always @(posedge pclk or negedge presetn) begin
        for (int i = 0; i < NPORT; i++) begin
            cnt[i]      <= (!presetn || !mode_req[i]) ? 0 : cnt[i] + 1;
            mode_ack[i] <= presetn && mode_req[i] && cnt[i] >= DELAY;
        end
    end
endmodule : port_mode_model

/* File: testbench/test_part_state_ctrl.sv */
// Bench for the partition state controller: APB tasks, directed tests.
// Assumes the port-mode stand-in and the bound checker.
`timescale 1ns/10ps
module test_part_state_ctrl;
    import part_state_pkg::*;
    localparam int DC = 40;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [3:0]  pin_n, prs, pact;
    logic [7:0]  mreq, mack, frc, prt;
    int          fails, cmp_count, cyc, n, t0;

    part_state_ctrl #(.DRAIN_CYC(DC)) part_state_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .partition_reset_input_n(pin_n), .mode_req(mreq),
        .mode_ack(mack), .part_reset(prs), .part_active(pact), .port_force_disabled(frc), .port_reset(prt));
    port_mode_model port_mode_model_i (.pclk, .presetn, .mode_req(mreq), .mode_ack(mack));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv      = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wait_done(input logic [11:0] a);
        n = 0;
        do begin
            bus(1'b0, a, 32'h0);
            n++;
        end while (rv[STS_DONE_BIT] !== 1'b1 && n < 300);
        chk("done", 32'h1, rv[STS_DONE_BIT]);
    endtask : wait_done

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        pin_n = 4'hf;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        bus(1'b0, OFF_CTL_BASE, 32'h0);
        chk("ctl0", 32'h0, rv);
        bus(1'b0, OFF_TIMER, 32'h0);
        chk("timer", 32'h04010404, rv);
        bus(1'b0, 12'hffc, 32'h0);
        chk("unmapped", 32'h0, rv);
        $display("test reset values done");
        bus(1'b1, OFF_PORT_BASE, 32'h1);
        bus(1'b1, OFF_CTL_BASE, 32'(PST_FRESET));
        t0 = cyc;
        bus(1'b0, OFF_STS_BASE, 32'h0);
        chk("begun", 32'h1, rv[1:0]);
        chk("port rst", 32'h1, prt[0]);
        wait_done(OFF_STS_BASE);
        chk("drain", 32'h1, (cyc - t0 >= DC) && (cyc - t0 <= DC + 20));
        chk("in reset", 32'h1, prs[0]);
        bus(1'b0, OFF_PORT_BASE, 32'h0);
        chk("port0", 32'h0, rv);
        bus(1'b1, OFF_STS_BASE, 32'h3);
        bus(1'b0, OFF_STS_BASE, 32'h0);
        chk("w1c", 32'h0, rv[1:0]);
        repeat (20) @(posedge pclk);
        chk("hold", 32'h1, prs[0]);
        $display("test reset entry done");
        bus(1'b1, OFF_TIMER, 32'h0);
        bus(1'b1, OFF_CTL_BASE, 32'(PST_ACTIVE));
        wait_done(OFF_STS_BASE);
        chk("fast", 32'h1, n <= 2);
        chk("active", 32'h1, pact[0]);
        pin_n[1] <= 1'b0;
        bus(1'b1, OFF_CTL_BASE + 12'h4, 32'(PST_ACTIVE));
        repeat (10) @(posedge pclk);
        bus(1'b0, OFF_STS_BASE + 12'h4, 32'h0);
        chk("held", 32'h0, rv[STS_DONE_BIT]);
        chk("pin seen", 32'h1, rv[STS_RESET_BIT]);
        pin_n[1] <= 1'b1;
        wait_done(OFF_STS_BASE + 12'h4);
        $display("test activation done");
        bus(1'b1, OFF_PORT_BASE + 12'h4, 32'h21);
        @(posedge pclk);
        chk("forced", 32'h1, frc[1]);
        bus(1'b1, OFF_CTL_BASE + 12'h8, 32'(PST_ACTIVE));
        wait_done(OFF_STS_BASE + 12'h8);
        chk("mode wait", 32'h1, n >= 3);
        chk("freed", 32'h0, frc[1]);
        bus(1'b1, OFF_TIMER, 32'h04010404);
        bus(1'b1, OFF_CTL_BASE + 12'h8, 32'(PST_DISABLED));
        wait_done(OFF_STS_BASE + 12'h8);
        chk("mode acked", 32'h0, mreq[1]);
        chk("forced again", 32'h1, frc[1]);
        bus(1'b1, OFF_CTL_BASE, 32'(PST_DISABLED));
        wait_done(OFF_STS_BASE);
        chk("off", 32'h0, pact[0]);
        $display("test port modes done");
        give_verdict();
    end
endmodule : test_part_state_ctrl
